// ### core/adc_out_pkg.sv
package adc_out_pkg;
    // ------------------------------------------------------------
    // Widths and codes
    // ------------------------------------------------------------
    localparam int DATA_W = 12;
    localparam logic [11:0] CODE_ZERO = 12'h000;
    localparam logic [11:0] CODE_MID = 12'h800;
    localparam logic [11:0] CODE_FULL = 12'hFFF;
    localparam logic [11:0] MSB_MASK = 12'h800;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int SAMPLE_DIV = 4;
    localparam logic [1:0] SAMPLE_DIV_LAST = 2'(SAMPLE_DIV - 1);
    localparam int PIPE_LATENCY = 3;
    localparam logic [1:0] PHASE_RESET = 2'h0;
    localparam logic [11:0] DATA_RESET = 12'h800;
    localparam int BUF_DEPTH = 2;
endpackage : adc_out_pkg

// ### core/adc_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface adc_link_if;
    logic [11:0] data;
    logic out_of_range_flag;
    logic valid;
    logic ready;
    modport converter (output data, output out_of_range_flag, output valid, input ready);
    modport capture (input data, input out_of_range_flag, input valid, output ready);
endinterface : adc_link_if
`default_nettype wire

// ### core/adc_converter_end.sv
`timescale 1ns/100ps
`default_nettype none
// Function
// - Results are unsigned straight binary, monotonic
// - Below range 000, zero 800, top FFF
// - Capture inverts MSB for two's complement
// - Flag travels with its sample's data
// - Flag high below negative or at positive reference
// - Flag clears only with next in-range sample
// - Capture decodes under/over range from flag, MSB
// - Conversion timing from both sample clock phases
// - Sample clock duty cycle kept within limits
// - Derived sample clock retimed by original clock
module adc_converter_end (
    // System clock, the only clock of the block
    input wire logic clk_i,
    // Synchronous reset, active low
    input wire logic resetn_i,
    // Model of the analog difference, in LSB
    input wire logic signed [12:0] diff_code_i,
    // High on the rising phase of the sample clock
    output logic sample_tick_o,
    // Sticky: a sample was lost to a full buffer
    output logic overflow_o,
    // Link to the capture end
    adc_link_if.converter link
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        // Position within the sample clock period
        logic [1:0] phase;
        // Conversion pipeline, newest stage at index 0
        logic [2:0][11:0] pipe_data;
        logic [2:0] pipe_flag;
        logic [2:0] pipe_vld;
        // Two-entry output buffer, flag in bit 12
        logic [1:0][12:0] buf_word;
        logic [1:0] buf_vld;
        // Sticky dropped-sample indicator
        logic overflow;
    } conv_state_t;

    conv_state_t st;
    conv_state_t next_st;

    // ------------------------------------------------------------
    // Internal signals
    // ------------------------------------------------------------
    // Sample clock phase decode
    logic rise_tick;
    logic fall_tick;
    logic last_phase;

    // Quantiser results
    logic below_range;
    logic above_range;
    logic [11:0] in_code;
    logic [11:0] code;
    logic flag;

    // Buffer handshake
    logic [12:0] out_word;
    logic out_ready;
    logic push;
    logic pop;
    logic head_free;
    logic tail_free;

    // ------------------------------------------------------------
    // Sample clock phases
    // ------------------------------------------------------------
    // Sample clock is a divided phase count of clk_i, so both of
    // its edges are plain decodes of one register in one domain.
    // Rising phase samples, falling phase moves results out.
    assign last_phase = (st.phase == adc_out_pkg::SAMPLE_DIV_LAST);
    assign rise_tick = (st.phase == adc_out_pkg::PHASE_RESET);
    assign fall_tick = (st.phase == 2'(adc_out_pkg::SAMPLE_DIV / 2));
    assign sample_tick_o = rise_tick;

    // ------------------------------------------------------------
    // Quantiser
    // ------------------------------------------------------------
    // In-range window is -2048..2047 in LSB.
    // Equal to the negative reference is still in range.
    assign below_range = (diff_code_i < -13'sd2048);
    assign above_range = (diff_code_i > 13'sd2047);
    assign in_code = diff_code_i[11:0] ^ adc_out_pkg::MSB_MASK;

    // Flag is per sample: the first in-range conversion clears it
    always_comb begin
        if (below_range) begin
            code = adc_out_pkg::CODE_ZERO;
            flag = 1'b1;
        end else if (above_range) begin
            code = adc_out_pkg::CODE_FULL;
            flag = 1'b1;
        end else begin
            code = in_code;
            flag = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Output buffer control
    // ------------------------------------------------------------
    // Data and flag leave the pipeline as one word
    assign out_word = {st.pipe_flag[2], st.pipe_data[2]};
    assign out_ready = link.ready;
    // Head leaves whenever the capture end is ready
    assign pop = st.buf_vld[0] && out_ready;
    // One push per sample period, at the falling phase
    assign push = fall_tick && st.pipe_vld[2];

    // Slot state after this cycle's pop
    always_comb begin
        head_free = 1'b0;
        tail_free = 1'b0;
        case (st.buf_vld)
            2'b00: begin
                head_free = 1'b1;
                tail_free = 1'b1;
            end
            2'b01: begin
                head_free = pop;
                tail_free = 1'b1;
            end
            default: begin
                head_free = 1'b0;
                tail_free = pop;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        // Phase counter: one sample clock period per wrap
        if (last_phase) begin
            next_st.phase = adc_out_pkg::PHASE_RESET;
        end else begin
            next_st.phase = st.phase + 2'h1;
        end

        // Data and flag share one pipeline, so equal latency
        if (rise_tick) begin
            next_st.pipe_data = {st.pipe_data[1:0], code};
            next_st.pipe_flag = {st.pipe_flag[1:0], flag};
            next_st.pipe_vld = {st.pipe_vld[1:0], 1'b1};
        end

        // Second entry moves up when the head is taken
        if (pop) begin
            next_st.buf_word[0] = st.buf_word[1];
            next_st.buf_word[1] = '0;
            next_st.buf_vld = {1'b0, st.buf_vld[1]};
        end

        // Converter cannot stall: a full buffer drops the sample
        // and leaves the sticky overflow set until reset.
        if (push) begin
            if (head_free) begin
                next_st.buf_word[0] = out_word;
                next_st.buf_vld[0] = 1'b1;
            end else if (tail_free) begin
                next_st.buf_word[1] = out_word;
                next_st.buf_vld[1] = 1'b1;
            end else begin
                next_st.overflow = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Pipeline idles at mid code with the flag low
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            st.phase <= adc_out_pkg::PHASE_RESET;
            st.pipe_data <= {3{adc_out_pkg::DATA_RESET}};
            st.pipe_flag <= 3'h0;
            st.pipe_vld <= 3'h0;
            st.buf_word <= '0;
            st.buf_vld <= 2'h0;
            st.overflow <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Link and status outputs
    // ------------------------------------------------------------
    // Head of the buffer drives the link straight from flip-flops
    assign link.data = st.buf_word[0][11:0];
    assign link.out_of_range_flag = st.buf_word[0][12];
    assign link.valid = st.buf_vld[0];
    assign overflow_o = st.overflow;
endmodule : adc_converter_end
`default_nettype wire

// ### core/adc_capture_end.sv
`timescale 1ns/100ps
`default_nettype none
module adc_capture_end (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic hold_i,
    output logic [11:0] sample_o,
    output logic signed [11:0] signed_sample_o,
    output logic under_range_o,
    output logic over_range_o,
    output logic sample_valid_o,
    adc_link_if.capture link
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [11:0] sample;
        logic [11:0] signed_sample;
        logic under;
        logic over;
        logic vld;
    } cap_state_t;

    cap_state_t st;
    cap_state_t next_st;

    assign link.ready = !hold_i;

    always_comb begin
        next_st = st;
        next_st.vld = 1'b0;
        if (link.valid && !hold_i) begin
            next_st.sample = link.data;
            next_st.signed_sample = link.data ^ adc_out_pkg::MSB_MASK;
            next_st.under = link.out_of_range_flag && !link.data[11];
            next_st.over = link.out_of_range_flag && link.data[11];
            next_st.vld = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            st.sample <= adc_out_pkg::DATA_RESET;
            st.signed_sample <= 12'h000;
            st.under <= 1'b0;
            st.over <= 1'b0;
            st.vld <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign sample_o = st.sample;
    assign signed_sample_o = st.signed_sample;
    assign under_range_o = st.under;
    assign over_range_o = st.over;
    assign sample_valid_o = st.vld;
endmodule : adc_capture_end
`default_nettype wire

// ### test/adc_link_properties.sv
`timescale 1ns/100ps
`default_nettype none
module adc_link_properties (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [11:0] data,
    input wire logic out_of_range_flag,
    input wire logic valid,
    input wire logic ready
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    a_stall_data_held: assert property (
        valid && !ready |=> valid && $stable(data)) else $error("data moved in stall");
    a_stall_flag_held: assert property (
        valid && !ready |=> $stable(out_of_range_flag)) else $error("flag moved in stall");
    a_flag_end_code: assert property (
        valid && out_of_range_flag |-> data == 12'h000 || data == 12'hFFF)
        else $error("flag on mid code");
    a_word_rate: assert property (
        $fell(valid) |-> ##[1:5] valid) else $error("word late");
    a_reset_idle: assert property (
        $rose(resetn_i) |-> !valid && !out_of_range_flag) else $error("word after reset");
    a_under_zero: assert property (
        valid && out_of_range_flag && !data[11] |-> data == 12'h000)
        else $error("under range not zero");
    cover property (valid && !ready);
    cover property (valid && out_of_range_flag && data[11]);
    cover property (valid && out_of_range_flag && !data[11]);
endmodule : adc_link_properties
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic hold_i = 1'b0;
    logic signed [12:0] diff_code_i = 13'sh0;
    logic [11:0] sample_o;
    logic signed [11:0] signed_sample_o;
    logic under_range_o, over_range_o, sample_valid_o, overflow_o;
    int fails = 0;
    int n_checks = 0;
    int n_tick = 0;
    logic sample_tick_o;
    int codes[7] = '{-3000, -2048, 0, 5, 2047, 2048, 7};
    adc_link_if adc_link_if_i ();
    adc_converter_end adc_converter_end_i (.clk_i(clk_i), .resetn_i(resetn_i),
        .diff_code_i(diff_code_i), .sample_tick_o(sample_tick_o), .overflow_o(overflow_o),
        .link(adc_link_if_i.converter));
    adc_capture_end adc_capture_end_i (.clk_i(clk_i), .resetn_i(resetn_i),
        .hold_i(hold_i), .sample_o(sample_o), .signed_sample_o(signed_sample_o),
        .under_range_o(under_range_o), .over_range_o(over_range_o),
        .sample_valid_o(sample_valid_o), .link(adc_link_if_i.capture));
    adc_link_properties adc_link_properties_i (.clk_i(clk_i), .resetn_i(resetn_i),
        .data(adc_link_if_i.data), .out_of_range_flag(adc_link_if_i.out_of_range_flag),
        .valid(adc_link_if_i.valid), .ready(adc_link_if_i.ready));
    initial forever #4 clk_i = ~clk_i;
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Hold one input level, then check the captured word and range decode
    task automatic apply(input int code);
        logic [11:0] e;
        logic f;
        int n;
        f = code < -2048 || code > 2047;
        e = code < -2048 ? 12'h000 : code > 2047 ? 12'hFFF : 12'(code + 2048);
        @(negedge clk_i) diff_code_i <= 13'(code);
        repeat (24) @(negedge clk_i);
        n = 0;
        while (sample_valid_o !== 1'b1 && n < 20) begin
            @(negedge clk_i);
            n++;
        end
        chk(sample_o, e);
        chk(signed_sample_o, e ^ 12'h800);
        chk({11'h0, under_range_o}, {11'h0, f & !e[11]});
        chk({11'h0, over_range_o}, {11'h0, f & e[11]});
    endtask : apply
    initial begin
        repeat (4) @(negedge clk_i);
        resetn_i <= 1'b1;
        repeat (8) begin
            @(negedge clk_i);
            n_tick += sample_tick_o;
        end
        chk(12'(n_tick), 12'h002);
        foreach (codes[i]) apply(codes[i]);
        chk({11'h0, overflow_o}, 12'h000);
        @(negedge clk_i) hold_i <= 1'b1;
        repeat (40) @(negedge clk_i);
        chk({11'h0, adc_link_if_i.valid}, 12'h001);
        chk({11'h0, overflow_o}, 12'h001);
        @(negedge clk_i) hold_i <= 1'b0;
        apply(-100);
        report_and_stop;
    end
    initial begin
        repeat (3000) @(posedge clk_i);
        fails++;
        report_and_stop;
    end
endmodule : tb_top
`default_nettype wire
